// ### core/flash_seq_pkg.sv
package flash_seq_pkg;

	// opcodes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_AUTO_PROGRAM = 8'haf;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_ID_READ_A = 8'h90;
	localparam logic [7:0] OP_ID_READ_B = 8'hab;

	// identification bytes: arbitrary neutral values
	localparam logic [7:0] MAKER_CODE = 8'h5a;
	localparam logic [7:0] PART_CODE = 8'h3c;

	// status register bit positions and power-up value
	localparam int ST_BUSY = 0;
	localparam int ST_WRITE_EN = 1;
	localparam int ST_PROT_LOW = 2;
	localparam int ST_PROT_HIGH = 3;
	localparam int ST_AUTO_PROG = 6;
	localparam int ST_LOCK = 7;
	localparam logic [7:0] STATUS_RESET = 8'h0c;

	// addressing: highest address bit of the array, erase granules
	localparam int TOP_ADDR_BIT = 18;
	localparam logic [23:0] ADDR_MASK = 24'h07ffff;
	localparam logic [23:0] SECTOR_MASK = 24'hfff000;
	localparam logic [23:0] BLOCK_MASK = 24'hff8000;

	// whole bus cycles each instruction must carry
	localparam logic [2:0] LEN_OPCODE = 3'h1;
	localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
	localparam logic [2:0] LEN_AUTO_NEXT = 3'h2;
	localparam logic [2:0] LEN_ADDRESS = 3'h4;
	localparam logic [2:0] LEN_PROGRAM = 3'h5;
	localparam logic [2:0] BYTE_LAST_ADDR = 3'h3;
	localparam logic [2:0] BYTE_DATA = 3'h4;
	localparam logic [2:0] BYTE_MAX = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic [2:0] {
		ARR_IDLE = 3'b000,
		ARR_BYTE_PROGRAM = 3'b001,
		ARR_SECTOR_ERASE = 3'b010,
		ARR_BLOCK_ERASE = 3'b011,
		ARR_CHIP_ERASE = 3'b100
	} array_op_t;

	// link working state, cleared whenever chip select is high
	typedef struct packed {
		logic started;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shift;
		logic out_active;
	} link_work_t;

	// frame record, survives the frame end so the core can act on it
	typedef struct packed {
		logic frame_tog;
		logic whole;
		logic [2:0] bytes;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] data;
		logic [7:0] st_meta;
		logic [7:0] st_sync;
	} link_rec_t;

	// serial output stage on the falling edge
	typedef struct packed {
		logic [7:0] shift;
		logic so;
		logic oe_n;
	} link_tx_t;

	// core state on the system clock
	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic wp_meta;
		logic wp_sync;
		logic seen_tog;
		logic busy;
		logic write_enable_latch;
		logic protect_level_low;
		logic protect_level_high;
		logic auto_increment_program_mode;
		logic protect_lock;
		logic armed;
		logic top_hit;
		logic [23:0] auto_addr;
		logic array_req;
		array_op_t array_op;
		logic [23:0] array_addr;
		logic [7:0] array_data;
	} core_t;

endpackage

// ### core/flash_seq.sv
`timescale 1ns/100ps
// Behaviour
// - status bit 0 is busy: set during program or erase, read-only, reset 0
// - status bit 1 is write enable latch; when 0 program and erase are rejected
// - latch clears on reset, write disable, program or erase done, auto program top
// - protection bits sit at status bits 2 and 3, writable, both 1 at reset
// - protection levels none, top quarter, upper half, all; protected writes ignored
// - status write updates protection only if protect pin high or lock 0
// - lock bit 7 resets 0; pin low and lock 1 freezes lock and protection
// - chip erase only runs with both protection bits 0
// - status bit 6 shows auto increment program mode, read-only, reset 0
// - instruction starts at select fall; input sampled on rising edge, msb first
// - select rising mid byte abandons the instruction
// - read 03, byte program 02, auto program af with three address bytes
// - sector erase 20, block erase 52 with address; chip erase 60 alone
// - status read 05, write enable 06, write disable 04 also ends auto mode
// - status read repeats the status byte until select rises
// - status write arm 50 must be directly followed by status write 01
// - id read 90 or ab, address bit 0 picks maker or part, repeats
// - address bits above top bit ignored; sector and block use upper bits
// - output shifts on falling edge and floats during command and address
// - select low for whole sequence; falling edge selects device
module flash_seq
	import flash_seq_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	input wire logic wp_n,
	output logic [23:0] mem_read_addr,
	input wire logic [7:0] mem_read_data,
	output logic array_req,
	output array_op_t array_op,
	output logic [23:0] array_addr,
	output logic [7:0] array_data,
	input wire logic array_done,
	output logic [7:0] status_byte
);

	link_work_t w_q, w_d;
	link_rec_t r_q, r_d;
	link_tx_t t_q, t_d;
	core_t c_q, c_d;
	logic link_rst;
	logic byte_done;
	logic [7:0] new_byte;
	logic auto_next;
	logic [7:0] tx_src;
	logic [23:0] rec_addr_m;
	logic [23:0] next_auto_addr;
	logic locked;
	logic may_write;
	logic [7:0] status_now;

	// protection window of the upper address bits
	function automatic logic is_protected(input logic [23:0] a, input logic [1:0] lvl);
		logic p;
		p = 1'b0;
		unique case (lvl)
			2'b00: p = 1'b0;
			2'b01: p = a[TOP_ADDR_BIT] & a[TOP_ADDR_BIT-1];
			2'b10: p = a[TOP_ADDR_BIT];
			2'b11: p = 1'b1;
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// link side, clocked by the serial clock

	// select high holds the frame logic idle, so a short frame leaves nothing behind
	assign link_rst = rst | cs_n;
	assign byte_done = (w_q.bit_cnt == BIT_LAST);
	assign new_byte = {w_q.shift[6:0], si};
	assign auto_next = (r_q.opcode == OP_AUTO_PROGRAM) && r_q.st_sync[ST_AUTO_PROG];

	// bit and byte counting inside a frame
	always_comb begin
		w_d = w_q;
		w_d.started = 1'b1;
		w_d.shift = new_byte;
		w_d.bit_cnt = w_q.bit_cnt + 3'h1;
		if (byte_done) begin
			if (w_q.byte_cnt != BYTE_MAX)
				w_d.byte_cnt = w_q.byte_cnt + 3'h1;
			// output starts on the byte after the opcode or the last address byte
			if (w_q.byte_cnt == 3'h0 && new_byte == OP_STATUS_READ)
				w_d.out_active = 1'b1;
			if (w_q.byte_cnt == BYTE_LAST_ADDR && (r_q.opcode == OP_READ
					|| r_q.opcode == OP_ID_READ_A || r_q.opcode == OP_ID_READ_B))
				w_d.out_active = 1'b1;
		end
	end

	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst)
			w_q <= '0;
		else
			w_q <= w_d;
	end

	// frame record; the status copy crosses in bit by bit through two flops
	always_comb begin
		r_d = r_q;
		r_d.st_meta = status_now;
		r_d.st_sync = r_q.st_meta;
		if (!w_q.started)
			r_d.frame_tog = ~r_q.frame_tog;
		r_d.whole = byte_done;
		if (byte_done) begin
			r_d.bytes = (w_q.byte_cnt == BYTE_MAX) ? BYTE_MAX : w_q.byte_cnt + 3'h1;
			if (w_q.byte_cnt == 3'h0)
				r_d.opcode = new_byte;
			else if (w_q.byte_cnt == 3'h1 && (auto_next || r_q.opcode == OP_STATUS_WRITE))
				r_d.data = new_byte;
			else if (w_q.byte_cnt <= BYTE_LAST_ADDR)
				r_d.addr = {r_q.addr[15:0], new_byte};
			else if (w_q.byte_cnt == BYTE_DATA && r_q.opcode != OP_READ)
				r_d.data = new_byte;
			// read streams on through the array and wraps at the top
			if (w_q.byte_cnt >= BYTE_DATA && r_q.opcode == OP_READ)
				r_d.addr = r_q.addr + 24'h1;
		end
	end

	always_ff @(posedge sck or posedge rst) begin
		if (rst)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign mem_read_addr = r_q.addr & ADDR_MASK;

	// byte presented at each output byte boundary
	always_comb begin
		tx_src = 8'h00;
		if (r_q.opcode == OP_STATUS_READ)
			tx_src = r_q.st_sync;
		else if (r_q.opcode == OP_READ)
			tx_src = mem_read_data;
		else if (r_q.addr[0])
			tx_src = PART_CODE;
		else
			tx_src = MAKER_CODE;
	end

	// falling edge output; floats unless an output phase is open
	always_comb begin
		t_d = t_q;
		t_d.oe_n = ~w_q.out_active;
		if (w_q.out_active) begin
			if (w_q.bit_cnt == 3'h0) begin
				t_d.so = tx_src[7];
				t_d.shift = {tx_src[6:0], 1'b0};
			end else begin
				t_d.so = t_q.shift[7];
				t_d.shift = {t_q.shift[6:0], 1'b0};
			end
		end
	end

	always_ff @(negedge sck or posedge link_rst) begin
		if (link_rst)
			t_q <= '{shift: 8'h00, so: 1'b0, oe_n: 1'b1};
		else
			t_q <= t_d;
	end

	assign so = t_q.so;
	assign so_oe_n = t_q.oe_n;

	////////////////////////////////////////////////////////////////////////////
	// core side, system clock

	assign status_now = {c_q.protect_lock, c_q.auto_increment_program_mode, 2'b00,
		c_q.protect_level_high, c_q.protect_level_low, c_q.write_enable_latch,
		c_q.busy};
	assign rec_addr_m = r_q.addr & ADDR_MASK;
	assign next_auto_addr = (c_q.auto_addr + 24'h1) & ADDR_MASK;
	assign locked = ~c_q.wp_sync & c_q.protect_lock;
	// program and erase need the latch and an idle array
	assign may_write = c_q.write_enable_latch & ~c_q.busy;

	// instruction execution at the select rising edge, and array completion
	always_comb begin
		c_d = c_q;
		c_d.array_req = 1'b0;
		c_d.cs_meta = cs_n;
		c_d.cs_sync = c_q.cs_meta;
		c_d.cs_prev = c_q.cs_sync;
		c_d.wp_meta = wp_n;
		c_d.wp_sync = c_q.wp_meta;
		if (array_done && c_q.busy) begin
			c_d.busy = 1'b0;
			if (!c_q.auto_increment_program_mode || c_q.top_hit) begin
				c_d.write_enable_latch = 1'b0;
				c_d.auto_increment_program_mode = 1'b0;
			end
		end
		// the record is quiet here: the serial clock has stopped with select high
		if (c_q.cs_sync && !c_q.cs_prev && r_q.frame_tog != c_q.seen_tog) begin
			c_d.seen_tog = r_q.frame_tog;
			c_d.armed = 1'b0;
			if (r_q.whole) begin
				unique case (r_q.opcode)
					OP_WRITE_ENABLE: begin
						if (r_q.bytes == LEN_OPCODE && !c_q.busy)
							c_d.write_enable_latch = 1'b1;
					end
					OP_WRITE_DISABLE: begin
						if (r_q.bytes == LEN_OPCODE) begin
							c_d.write_enable_latch = 1'b0;
							c_d.auto_increment_program_mode = 1'b0;
						end
					end
					OP_STATUS_WRITE_ARM: begin
						if (r_q.bytes == LEN_OPCODE && !c_q.busy)
							c_d.armed = 1'b1;
					end
					OP_STATUS_WRITE: begin
						if (r_q.bytes == LEN_STATUS_WRITE && c_q.armed && !locked) begin
							c_d.protect_level_low = r_q.data[ST_PROT_LOW];
							c_d.protect_level_high = r_q.data[ST_PROT_HIGH];
							c_d.protect_lock = r_q.data[ST_LOCK];
						end
					end
					OP_BYTE_PROGRAM: begin
						if (r_q.bytes == LEN_PROGRAM && may_write
								&& !c_q.auto_increment_program_mode
								&& !is_protected(rec_addr_m, status_now[ST_PROT_HIGH:ST_PROT_LOW])) begin
							c_d.busy = 1'b1;
							c_d.array_req = 1'b1;
							c_d.array_op = ARR_BYTE_PROGRAM;
							c_d.array_addr = rec_addr_m;
							c_d.array_data = r_q.data;
						end
					end
					OP_AUTO_PROGRAM: begin
						// first byte carries an address, the rest follow on
						if (!c_q.auto_increment_program_mode) begin
							if (r_q.bytes == LEN_PROGRAM && may_write
									&& !is_protected(rec_addr_m,
									status_now[ST_PROT_HIGH:ST_PROT_LOW])) begin
								c_d.auto_increment_program_mode = 1'b1;
								c_d.busy = 1'b1;
								c_d.array_req = 1'b1;
								c_d.array_op = ARR_BYTE_PROGRAM;
								c_d.array_addr = rec_addr_m;
								c_d.array_data = r_q.data;
								c_d.auto_addr = rec_addr_m;
								c_d.top_hit = (rec_addr_m == ADDR_MASK);
							end
						end else if (r_q.bytes == LEN_AUTO_NEXT && may_write
								&& !is_protected(next_auto_addr,
								status_now[ST_PROT_HIGH:ST_PROT_LOW])) begin
							c_d.busy = 1'b1;
							c_d.array_req = 1'b1;
							c_d.array_op = ARR_BYTE_PROGRAM;
							c_d.array_addr = next_auto_addr;
							c_d.array_data = r_q.data;
							c_d.auto_addr = next_auto_addr;
							c_d.top_hit = (next_auto_addr == ADDR_MASK);
						end
					end
					OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
						if (r_q.bytes == LEN_ADDRESS && may_write
								&& !is_protected(rec_addr_m, status_now[ST_PROT_HIGH:ST_PROT_LOW])) begin
							c_d.busy = 1'b1;
							c_d.array_req = 1'b1;
							c_d.top_hit = 1'b0;
							if (r_q.opcode == OP_SECTOR_ERASE) begin
								c_d.array_op = ARR_SECTOR_ERASE;
								c_d.array_addr = rec_addr_m & SECTOR_MASK;
							end else begin
								c_d.array_op = ARR_BLOCK_ERASE;
								c_d.array_addr = rec_addr_m & BLOCK_MASK;
							end
						end
					end
					OP_CHIP_ERASE: begin
						if (r_q.bytes == LEN_OPCODE && may_write && !c_q.protect_level_low
								&& !c_q.protect_level_high) begin
							c_d.busy = 1'b1;
							c_d.array_req = 1'b1;
							c_d.top_hit = 1'b0;
							c_d.array_op = ARR_CHIP_ERASE;
							c_d.array_addr = 24'h000000;
						end
					end
					// reads and unknown opcodes change nothing here
					default: c_d.armed = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			c_q <= '0;
			c_q.cs_meta <= 1'b1;
			c_q.cs_sync <= 1'b1;
			c_q.cs_prev <= 1'b1;
			c_q.protect_level_low <= STATUS_RESET[ST_PROT_LOW];
			c_q.protect_level_high <= STATUS_RESET[ST_PROT_HIGH];
		end else begin
			c_q <= c_d;
		end
	end

	assign array_req = c_q.array_req;
	assign array_op = c_q.array_op;
	assign array_addr = c_q.array_addr;
	assign array_data = c_q.array_data;
	assign status_byte = status_now;

endmodule // flash_seq

// ### bench/flash_seq_assertions.sv
`timescale 1ns/100ps
module flash_seq_assertions
	import flash_seq_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic so_oe_n,
	input wire logic array_req,
	input wire array_op_t array_op,
	input wire logic [23:0] array_addr,
	input wire logic array_done,
	input wire logic [7:0] status_byte
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// a request is a lone pulse and busy rises with it
	sequence req_s;
		status_byte[ST_BUSY] ##1 !array_req;
	endsequence

	a_req_single: assert property (array_req |-> req_s)
		else $error("request not a lone pulse with busy");
	a_req_ready: assert property (array_req |-> !$past(status_byte[ST_BUSY]))
		else $error("request while busy");
	a_req_enabled: assert property (array_req |-> $past(status_byte[ST_WRITE_EN]))
		else $error("request without write enable");
	a_chip_open: assert property (array_req && array_op == ARR_CHIP_ERASE
		|-> $past(status_byte[3:2]) == 2'h0)
		else $error("chip erase while protected");
	a_sector_align: assert property (array_req && array_op == ARR_SECTOR_ERASE
		|-> array_addr[11:0] == 12'h000)
		else $error("sector address not aligned");
	a_block_align: assert property (array_req && array_op == ARR_BLOCK_ERASE
		|-> array_addr[14:0] == 15'h0000)
		else $error("block address not aligned");
	a_addr_range: assert property (array_req |-> array_addr[23:19] == 5'h00)
		else $error("address above top bit");
	// busy only drops once the array reports completion
	a_busy_holds: assert property (status_byte[ST_BUSY] && !array_done
		&& !$past(array_done) |=> status_byte[ST_BUSY])
		else $error("busy dropped early");
	a_busy_ends: assert property (status_byte[ST_BUSY] && array_done
		|-> ##[1:2] !status_byte[ST_BUSY])
		else $error("busy stuck after done");
	a_float_idle: assert property (cs_n |-> so_oe_n)
		else $error("output driven while deselected");
endmodule // flash_seq_assertions

bind flash_seq flash_seq_assertions u_chk (.clock(clock), .rst(rst), .cs_n(cs_n),
	.so_oe_n(so_oe_n), .array_req(array_req), .array_op(array_op),
	.array_addr(array_addr), .array_done(array_done), .status_byte(status_byte));

// ### bench/host_model.sv
`timescale 1ns/100ps
module host_model
(
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe_n
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// mode 0 frame: nbits sent msb first, then nrd bytes read; sck idles low
	task automatic frame(input logic [39:0] tx, input int nbits, input int nrd,
		output logic [15:0] rx);
		rx = 16'hxxxx;
		#7 cs_n = 1'b0;
		for (int i = 0; i < nbits + nrd * 8; i++) begin
			si = (i < nbits) ? tx[39 - i] : ~si;
			#62.5 sck = 1'b1;
			// a floating output reads as unknown so it only matches an expected x
			if (i >= nbits) rx[15 - (i - nbits)] = so_oe_n ? 1'bx : so;
			#62.5 sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		si = ~si;
		#500;
	endtask
endmodule // host_model

// ### bench/flash_seq_bench.sv
`timescale 1ns/100ps
module flash_seq_bench;
	import flash_seq_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic array_done = 1'b0;
	logic sck, cs_n, si, so, so_oe_n, array_req, p;
	logic [23:0] mem_read_addr, array_addr, cap_addr, a;
	logic [7:0] mem_read_data, array_data, status_byte, cap_data, d, op8;
	logic [7:0] seed = 8'h0e;
	logic [15:0] rx;
	array_op_t array_op, cap_op, aop;
	int fails = 0;
	int n_compared = 0;
	int n_req = 0;
	int hold = 5;
	int n0;
	localparam logic [23:0] CORNER [4] = '{24'h05ffff, 24'h060000, 24'hf3ffff, 24'h040000};

	flash_seq u_flash_seq (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
		.so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .mem_read_addr(mem_read_addr),
		.mem_read_data(mem_read_data), .array_req(array_req), .array_op(array_op),
		.array_addr(array_addr), .array_data(array_data), .array_done(array_done),
		.status_byte(status_byte));
	host_model u_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

	always #25 clock = ~clock;
	assign mem_read_data = mem_read_addr[7:0] ^ 8'h5c;

	////////////////////////////////////////////////////////////////
	// array stand-in: records each request, answers after hold cycles
	always begin
		@(posedge clock);
		#1;
		if (array_req === 1'b1) begin
			n_req++;
			cap_op = array_op;
			cap_addr = array_addr;
			cap_data = array_data;
			repeat (hold) @(posedge clock);
			#1 array_done = 1'b1;
			@(posedge clock);
			#1 array_done = 1'b0;
		end
	end

	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction
	// protected region per level, top two address bits only so upper junk is ignored
	function automatic logic prot(input logic [1:0] lv, input logic [23:0] ad);
		case (lv)
			2'h0: prot = 1'b0;
			2'h1: prot = ad[TOP_ADDR_BIT] & ad[TOP_ADDR_BIT - 1];
			2'h2: prot = ad[TOP_ADDR_BIT];
			default: prot = 1'b1;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [39:0] tx, input int nb);
		u_host_model.frame(tx, nb * 8, 0, rx);
		for (int i = 0; i < 400 && status_byte[ST_BUSY] !== 1'b0; i++) @(posedge clock);
		// an operation that never ends is a mismatch, not a silent pass
		if (status_byte[ST_BUSY] !== 1'b0) begin
			fails++;
			$display("ERROR t=%0t busy never cleared", $time);
		end
	endtask
	// one instruction, then whether a request came and what it carried
	task automatic run(input logic [39:0] tx, input int nb, input int want,
		input array_op_t op, input logic [23:0] ad, input logic [7:0] dat);
		n0 = n_req;
		send(tx, nb);
		chk(n_req - n0, want);
		if (want == 1) begin
			chk(cap_op, op);
			if (op != ARR_CHIP_ERASE) chk(cap_addr, ad);
			if (op == ARR_BYTE_PROGRAM) chk(cap_data, dat);
		end
	endtask
	task automatic wsr(input logic [7:0] v);
		send({OP_STATUS_WRITE_ARM, 32'h0}, 1);
		send({OP_STATUS_WRITE, v, 24'h0}, 2);
	endtask
	task automatic test_done();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		$display("ERROR t=%0t watchdog expired", $time);
		fails++;
		test_done();
	end

	initial begin
		repeat (12) @(posedge clock);
		#1 rst = 1'b0;
		chk(status_byte, STATUS_RESET);
		u_host_model.frame({OP_STATUS_READ, 32'h0}, 8, 2, rx);
		chk(rx, {2{STATUS_RESET}});
		send({OP_STATUS_WRITE, 8'h00, 24'h0}, 2);
		chk(status_byte, STATUS_RESET);
		wsr(8'h00);
		run({OP_BYTE_PROGRAM, 24'h000100, 8'h55}, 5, 0, ARR_IDLE, 0, 0);
		chk(status_byte, 8'h00);
		@(posedge clock) #1 wp_n = 1'b0;
		wsr(8'h80);
		wsr(8'h0c);
		chk(status_byte, 8'h80);
		@(posedge clock) #1 wp_n = 1'b1;
		wsr(8'h00);
		chk(status_byte, 8'h00);
		// every level, boundary and random addresses, chip erase per level
		for (int l = 0; l < 4; l++) begin
			wsr({4'h0, l[1:0], 2'h0});
			send({OP_WRITE_ENABLE, 32'h0}, 1);
			run({OP_CHIP_ERASE, 32'h0}, 1, l == 0, ARR_CHIP_ERASE, 0, 0);
			send({OP_WRITE_DISABLE, 32'h0}, 1);
			for (int k = 0; k < 5; k++) begin
				a = (k < 4) ? CORNER[k] : {rnd(), rnd(), rnd()};
				d = rnd();
				p = prot(l[1:0], a);
				send({OP_WRITE_ENABLE, 32'h0}, 1);
				run({OP_BYTE_PROGRAM, a, d}, 5, !p, ARR_BYTE_PROGRAM, a & ADDR_MASK, d);
				chk(status_byte, {4'h0, l[1:0], p, 1'b0});
				send({OP_WRITE_DISABLE, 32'h0}, 1);
				chk(status_byte, {4'h0, l[1:0], 2'h0});
			end
		end
		wsr(8'h00);
		for (int k = 0; k < 2; k++) begin
			a = {rnd(), rnd(), rnd()};
			op8 = k ? OP_BLOCK_ERASE : OP_SECTOR_ERASE;
			aop = k ? ARR_BLOCK_ERASE : ARR_SECTOR_ERASE;
			a = k ? a & BLOCK_MASK : a & SECTOR_MASK;
			send({OP_WRITE_ENABLE, 32'h0}, 1);
			run({op8, a | 24'h000fff, 8'h0}, 4, 1, aop, a & ADDR_MASK, 0);
		end
		// a second erase sent while busy must be dropped
		hold = 300;
		send({OP_WRITE_ENABLE, 32'h0}, 1);
		n0 = n_req;
		u_host_model.frame({OP_SECTOR_ERASE, 24'h001000, 8'h0}, 32, 0, rx);
		u_host_model.frame({OP_BLOCK_ERASE, 24'h008000, 8'h0}, 32, 0, rx);
		u_host_model.frame({OP_STATUS_READ, 32'h0}, 8, 1, rx);
		chk(rx[15:8], 8'h03);
		send({OP_STATUS_READ, 32'h0}, 1);
		chk(n_req - n0, 1);
		chk(status_byte, 8'h00);
		hold = 5;
		u_host_model.frame({OP_WRITE_ENABLE, 32'h0}, 7, 0, rx);
		chk(status_byte, 8'h00);
		u_host_model.frame({8'hff, 32'h0}, 8, 1, rx);
		chk(rx[15:8], 8'hxx);
		chk(status_byte, 8'h00);
		u_host_model.frame({OP_READ, 24'h07ffff, 8'h0}, 32, 2, rx);
		chk(rx, {8'hff ^ 8'h5c, 8'h5c});
		for (int k = 0; k < 2; k++) begin
			op8 = k ? OP_ID_READ_B : OP_ID_READ_A;
			u_host_model.frame({op8, 16'h0, 7'h0, k[0], 8'h0}, 32, 2, rx);
			chk(rx, {2{k ? PART_CODE : MAKER_CODE}});
		end
		// auto program up to the top address, then a second run ended early
		send({OP_WRITE_ENABLE, 32'h0}, 1);
		run({OP_AUTO_PROGRAM, 24'h07fffe, 8'h11}, 5, 1, ARR_BYTE_PROGRAM,
			24'h07fffe, 8'h11);
		chk(status_byte, 8'h42);
		run({OP_AUTO_PROGRAM, 8'h22, 24'h0}, 2, 1, ARR_BYTE_PROGRAM, 24'h07ffff, 8'h22);
		chk(status_byte, 8'h00);
		send({OP_WRITE_ENABLE, 32'h0}, 1);
		run({OP_AUTO_PROGRAM, 24'h000010, 8'h33}, 5, 1, ARR_BYTE_PROGRAM,
			24'h000010, 8'h33);
		send({OP_WRITE_DISABLE, 32'h0}, 1);
		chk(status_byte, 8'h00);
		test_done();
	end
endmodule // flash_seq_bench
